// file: design/sar_ctl_pkg.sv
// Shared constants and types for the converter control block
`default_nettype none
package sar_ctl_pkg;

  // Resolution: 12 for the wide variant, 10 for the narrow one
  localparam int RES_BITS = 12;
  // Conversion length: sample cycle, one trial per bit, load cycle (14 or 12)
  localparam int CONV_CYC = RES_BITS + 2;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_HOLD_END = 4'(CONV_CYC - 2);
  localparam logic [CNT_W-1:0] CNT_LAST = 4'(CONV_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_STEPS = 4'(RES_BITS);

  // Timing figures in their own units
  localparam int CLK_PERIOD_PS = 25000;
  localparam int START_MIN_NS = 15;
  localparam int WAKE_TIME_US = 1;
  localparam int WAKE_CYC_RAW = (WAKE_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int WAKE_CYC = (WAKE_CYC_RAW < 1) ? 1 : WAKE_CYC_RAW;
  localparam int WAKE_W = 6;
  localparam logic [WAKE_W-1:0] WAKE_ZERO = 6'h00;
  localparam logic [WAKE_W-1:0] WAKE_LAST = 6'(WAKE_CYC - 1);

  // Reset values
  localparam logic [RES_BITS-1:0] RESULT_RST = 12'h000;
  localparam logic PIN_IDLE = 1'b1;

  // Host strobes that gate the result bus
  typedef struct packed {
    logic cs_n;
    logic rd_n;
  } bus_ctl_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_SLEEP = 2'b10,
    ST_WAKE = 2'b11
  } conv_state_t;

endpackage
`default_nettype wire

// file: design/sar_trial_reg.sv
// Successive-approximation trial register
`default_nettype none
module sar_trial_reg
(
  input wire logic clock_in,                                   // Master clock
  input wire logic rst_b_in,                                   // Sync reset, active low
  input wire logic start_in,                                   // Load first trial (MSB set)
  input wire logic step_in,                                    // Judge current bit, try next
  input wire logic above_in,                                   // Comparator: input above trial
  output logic [sar_ctl_pkg::RES_BITS-1:0] code_out            // Trial code, final after last step
);
  import sar_ctl_pkg::*;

  logic [RES_BITS-1:0] code_ff;
  logic [RES_BITS-1:0] mask_ff;
  logic [RES_BITS-1:0] nxt_code;
  logic [RES_BITS-1:0] nxt_mask;
  logic [RES_BITS-1:0] msb;

  assign msb = {1'b1, {(RES_BITS-1){1'b0}}};

  //////////////////////////////////////////////////////////////////////////////
  // Bit decision: keep the tried bit when the input is above, then try the next
  always_comb
  begin
    nxt_code = code_ff;
    nxt_mask = mask_ff;
    if (start_in)
    begin
      nxt_code = msb;
      nxt_mask = msb;
    end
    else if (step_in)
    begin
      nxt_mask = mask_ff >> 1;
      nxt_code = (above_in ? code_ff : (code_ff & ~mask_ff)) | nxt_mask;
    end
  end

  // Registers only
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      code_ff <= RESULT_RST;
      mask_ff <= RESULT_RST;
    end
    else
    begin
      code_ff <= nxt_code;
      mask_ff <= nxt_mask;
    end
  end

  assign code_out = code_ff;

endmodule
`default_nettype wire

// file: design/sar_conv_ctl.sv
// Conversion, sleep and result-bus control of the successive-approximation converter
//
// Notes on behaviour
// RULE_01 - Result bus driven only while chip select and read are both low.
// RULE_02 - Host may tie chip select low and gate reads with read alone.
// RULE_03 - Both strobes held low: bus stays driven, new result after busy falls.
// RULE_04 - Falling conversion start moves track/hold to hold and starts converting.
// RULE_05 - A conversion start pulse of 15 ns minimum must be accepted; the code sees a start pulse only if it spans a clock edge.
// RULE_06 - Start still low at end of conversion: sleep when busy falls.
// RULE_07 - Next rising start edge wakes the part; wake takes about 1 us.
// RULE_08 - A conversion lasts 14 clocks (12-bit) or 12 clocks (10-bit).
// RULE_09 - Master clock blocked from conversion logic while not converting.
// RULE_10 - Busy rises after the start edge and stays high throughout conversion.
// RULE_11 - Busy falls only once the result sits in the output register.
// RULE_12 - Track/hold returns to track just before busy falls.
// RULE_13 - Three-state result bus of 10 or 12 bits.
// RULE_14 - Result is straight binary.
// RULE_15 - Host should keep the bus quiet during conversion.
// RULE_16 - Last result held stable until the next conversion overwrites it.
`default_nettype none
module sar_conv_ctl
(
  input wire logic clock_in,                                   // Master clock, 40 MHz
  input wire logic rst_b_in,                                   // Sync reset, active low
  input wire logic conversion_start_n_in,                      // Start pin, active low
  input wire sar_ctl_pkg::bus_ctl_t bus_ctl_in,                // Chip select and read, active low
  input wire logic above_in,                                   // Comparator, same clock
  output logic busy_out,                                       // Conversion running
  output logic hold_out,                                       // 1 hold, 0 track
  output logic sleep_out,                                      // Asleep or waking
  output logic conv_clk_en_out,                                // Clock gate for conversion logic
  output logic [sar_ctl_pkg::RES_BITS-1:0] trial_out,          // Trial code to the DAC
  output logic [sar_ctl_pkg::RES_BITS-1:0] result_bus_out,     // Result data
  output logic result_bus_oe_out                               // Result bus drive enable
);
  import sar_ctl_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: stage one feeds only stage two
  logic [2:0] pin_raw;
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic start_dly_ff;

  assign pin_raw = {conversion_start_n_in, bus_ctl_in.cs_n, bus_ctl_in.rd_n};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      always_ff @(posedge clock_in)
      begin
        if (!rst_b_in)
        begin
          sync1_ff[gi] <= PIN_IDLE;
          sync2_ff[gi] <= PIN_IDLE;
        end
        else
        begin
          sync1_ff[gi] <= pin_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  logic start_s;
  logic cs_s;
  logic rd_s;
  logic start_fall;
  logic start_rise;

  assign start_s = sync2_ff[2];
  assign cs_s = sync2_ff[1];
  assign rd_s = sync2_ff[0];

  // Edge detect on the settled copy; a pulse must span one clock edge to be seen
  assign start_fall = start_dly_ff & ~start_s; // RULE_05
  assign start_rise = ~start_dly_ff & start_s;

  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
      start_dly_ff <= PIN_IDLE;
    else
      start_dly_ff <= start_s;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  conv_state_t state_ff;
  conv_state_t nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [WAKE_W-1:0] wake_ff;
  logic [WAKE_W-1:0] nxt_wake;
  logic busy_ff;
  logic nxt_busy;
  logic hold_ff;
  logic nxt_hold;
  logic sleep_ff;
  logic nxt_sleep;
  logic clk_en_ff;
  logic nxt_clk_en;
  logic [RES_BITS-1:0] result_ff;
  logic [RES_BITS-1:0] nxt_result;
  logic sar_start;
  logic sar_step;
  logic [RES_BITS-1:0] sar_code;

  // Next-state logic; starts seen while waking are dropped, the host must wait
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_wake = wake_ff;
    nxt_busy = busy_ff;
    nxt_hold = hold_ff;
    nxt_sleep = sleep_ff;
    nxt_clk_en = clk_en_ff;
    nxt_result = result_ff;
    sar_start = 1'b0;
    sar_step = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        if (start_fall)
        begin
          nxt_state = ST_CONV;
          nxt_cnt = CNT_ZERO;
          nxt_hold = 1'b1; // RULE_04
          nxt_busy = 1'b1; // RULE_10
          nxt_clk_en = 1'b1; // RULE_09
          sar_start = 1'b1;
        end
      end
      ST_CONV:
      begin
        nxt_cnt = cnt_ff + 4'h1;
        sar_step = (cnt_ff < CNT_STEPS);
        if (cnt_ff == CNT_HOLD_END)
          nxt_hold = 1'b0; // RULE_12
        if (cnt_ff == CNT_LAST) // RULE_08
        begin
          nxt_result = sar_code; // RULE_14
          nxt_busy = 1'b0; // RULE_11
          nxt_clk_en = 1'b0; // RULE_09
          nxt_cnt = CNT_ZERO;
          if (!start_s)
          begin
            nxt_state = ST_SLEEP; // RULE_06
            nxt_sleep = 1'b1;
          end
          else
            nxt_state = ST_IDLE;
        end
      end
      ST_SLEEP:
      begin
        if (start_rise)
        begin
          nxt_state = ST_WAKE; // RULE_07
          nxt_wake = WAKE_ZERO;
        end
      end
      ST_WAKE:
      begin
        nxt_wake = wake_ff + 6'h01;
        if (wake_ff == WAKE_LAST)
        begin
          nxt_state = ST_IDLE; // RULE_07
          nxt_sleep = 1'b0;
          nxt_wake = WAKE_ZERO;
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Registers only; the result register changes only at the end of a conversion
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= CNT_ZERO;
      wake_ff <= WAKE_ZERO;
      busy_ff <= 1'b0;
      hold_ff <= 1'b0;
      sleep_ff <= 1'b0;
      clk_en_ff <= 1'b0;
      result_ff <= RESULT_RST;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      wake_ff <= nxt_wake;
      busy_ff <= nxt_busy;
      hold_ff <= nxt_hold;
      sleep_ff <= nxt_sleep;
      clk_en_ff <= nxt_clk_en;
      result_ff <= nxt_result; // RULE_16
    end
  end

  sar_trial_reg u_sar
  (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .start_in(sar_start),
    .step_in(sar_step),
    .above_in(above_in),
    .code_out(sar_code)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Result bus enable: a single AND of both strobes, so either one gates the read
  logic oe_ff;
  logic nxt_oe;

  always_comb
  begin
    nxt_oe = ~cs_s & ~rd_s; // RULE_01
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
      oe_ff <= 1'b0;
    else
      oe_ff <= nxt_oe; // RULE_13 RULE_03
  end

  // Outputs straight from flops
  assign busy_out = busy_ff;
  assign hold_out = hold_ff;
  assign sleep_out = sleep_ff;
  assign conv_clk_en_out = clk_en_ff;
  assign trial_out = sar_code;
  assign result_bus_out = result_ff;
  assign result_bus_oe_out = oe_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  logic [CNT_W:0] busy_len_ff;
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in || !busy_ff)
      busy_len_ff <= 5'h00;
    else
      busy_len_ff <= busy_len_ff + 5'h01;
  end

  a_bus_gating: assert property (result_bus_oe_out |-> $past(!cs_s && !rd_s)) // RULE_01
    else $error("Result bus driven without both strobes low");
  a_bus_held_on: assert property ((!cs_s && !rd_s) [*2] |-> result_bus_oe_out) // RULE_03
    else $error("Result bus not driven with strobes held low");
  a_start_holds: assert property ((state_ff == ST_IDLE && start_fall) |=> busy_out && hold_out) // RULE_04
    else $error("Start edge did not enter hold and busy");
  a_busy_length: assert property ($fell(busy_out) |-> busy_len_ff == 5'(CONV_CYC)) // RULE_08
    else $error("Conversion length wrong");
  a_busy_steady: assert property ((busy_out && state_ff == ST_CONV && cnt_ff != CNT_LAST) |=> busy_out) // RULE_10
    else $error("Busy dropped mid conversion");
  a_result_loaded: assert property ($fell(busy_out) |-> result_bus_out == $past(sar_code)) // RULE_11
    else $error("Result not loaded when busy fell");
  a_track_early: assert property ($fell(busy_out) |-> !$past(hold_out) && $past(hold_out, 2)) // RULE_12
    else $error("Track not resumed one cycle before busy fell");
  a_auto_sleep: assert property ($fell(busy_out) |-> sleep_out == !$past(start_s)) // RULE_06
    else $error("Sleep entry wrong at end of conversion");
  a_wake_time: assert property ($fell(sleep_out) |-> $past(wake_ff) == WAKE_LAST) // RULE_07
    else $error("Wake time wrong");
  a_clk_blocked: assert property (!busy_out |-> !conv_clk_en_out) // RULE_09
    else $error("Conversion clock enabled while idle");
  // The trial register may move only while the gate is open or at the start edge
  a_gate_quiet: assert property ((!conv_clk_en_out && !(state_ff == ST_IDLE && start_fall)) // RULE_09
    |=> $stable(trial_out))
    else $error("Trial code moved with the conversion clock gated");
  a_result_stable: assert property (!$fell(busy_out) |-> $stable(result_bus_out)) // RULE_16
    else $error("Result changed outside end of conversion");

  c_conversion: cover property ($fell(busy_out));
  c_sleep: cover property ($rose(sleep_out));
  c_wake: cover property ($fell(sleep_out));
  c_read: cover property ($rose(result_bus_oe_out) && !busy_out);

endmodule
`default_nettype wire

// file: sim/host_side.sv
// Host and analog-input model facing the converter control block
`default_nettype none
module host_side
(
  input wire logic clock_in,                        // Master clock
  input wire logic [sar_ctl_pkg::RES_BITS-1:0] trial_in, // Trial code
  output var logic conversion_start_n_out,          // Start pin, active low
  output var sar_ctl_pkg::bus_ctl_t bus_ctl_out,    // Chip select and read
  output logic above_out                            // Comparator result
);
  timeunit 1ns;
  timeprecision 100ps;
  import sar_ctl_pkg::*;
  logic [RES_BITS-1:0] vin;
  int since_rise = 1000;
  ////////////////////////////////////////////////////////////////
  // Ideal comparator: a bit is kept when the input reaches the trial
  assign above_out = (vin >= trial_in);
  initial
  begin
    vin = 12'h000;
    conversion_start_n_out = PIN_IDLE;
    bus_ctl_out = '{cs_n: 1'b1, rd_n: 1'b1};
  end
  // Edges since the wake edge, so a sleeping part is not restarted early
  always @(posedge clock_in)
    if (since_rise < 1000)
      since_rise <= since_rise + 1;
  ////////////////////////////////////////////////////////////////
  // One full clock low: spans an edge, so well beyond the minimum width
  task automatic start(input logic [RES_BITS-1:0] v, input logic keep_low);
    while (since_rise < WAKE_CYC + 4)
      @(posedge clock_in);
    @(posedge clock_in) #1;
    vin = v;
    conversion_start_n_out = 1'b0;
    @(posedge clock_in) #1;
    if (!keep_low)
      conversion_start_n_out = 1'b1;
  endtask
  // Rising edge that wakes a sleeping part
  task automatic release_start();
    @(posedge clock_in) #1;
    conversion_start_n_out = 1'b1;
    since_rise = 0;
  endtask
  // Strobes move only between conversions to keep the bus quiet
  task automatic strobes(input logic cs_n, input logic rd_n);
    @(posedge clock_in) #1;
    bus_ctl_out = '{cs_n: cs_n, rd_n: rd_n};
  endtask
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the converter control block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import sar_ctl_pkg::*;
  logic clock_in;
  logic rst_b_in;
  logic start_n;
  bus_ctl_t bus_ctl;
  logic above, busy, hold, sleep, clk_en, oe;
  logic [RES_BITS-1:0] trial, result;
  int num_errors = 0;
  int checks_done = 0;
  ////////////////////////////////////////////////////////////////
  sar_conv_ctl u_sar_conv_ctl (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .conversion_start_n_in(start_n), .bus_ctl_in(bus_ctl), .above_in(above),
    .busy_out(busy), .hold_out(hold), .sleep_out(sleep), .conv_clk_en_out(clk_en),
    .trial_out(trial), .result_bus_out(result), .result_bus_oe_out(oe));
  host_side u_host_side (.clock_in(clock_in), .trial_in(trial),
    .conversion_start_n_out(start_n), .bus_ctl_out(bus_ctl), .above_out(above));
  // 40 MHz clock
  initial
  begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [RES_BITS-1:0] e, input logic [RES_BITS-1:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic results();
    $display("Comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One conversion, judged cycle by cycle while busy stands
  task automatic run_conv(input logic [RES_BITS-1:0] v, input logic keep_low);
    int n;
    int h;
    logic [RES_BITS-1:0] last;
    logic exp_oe;
    n = 0;
    h = 0;
    last = result;
    exp_oe = !bus_ctl.cs_n && !bus_ctl.rd_n;
    u_host_side.start(v, keep_low);
    while (busy !== 1'b1 && n < 6)
    begin
      @(posedge clock_in) #1;
      n++;
    end
    chk("busy rise", 12'h001, RES_BITS'(n >= 1 && n <= 3));
    chk("hold at start", 12'h001, RES_BITS'(hold));
    chk("first trial", 12'h800, trial);
    n = 0;
    while (busy === 1'b1 && n < 40)
    begin
      n++;
      if (hold === 1'b1)
        h++;
      chk("clock gate", 12'h001, RES_BITS'(clk_en));
      chk("held result", last, result);
      chk("bus enable", RES_BITS'(exp_oe), RES_BITS'(oe));
      @(posedge clock_in) #1;
    end
    chk("busy cycles", RES_BITS'(CONV_CYC), RES_BITS'(n));
    chk("hold cycles", RES_BITS'(CONV_CYC - 1), RES_BITS'(h));
    chk("result", v, result);
    chk("sleep", RES_BITS'(keep_low), RES_BITS'(sleep));
    chk("gate idle", 12'h000, RES_BITS'(clk_en));
  endtask
  ////////////////////////////////////////////////////////////////
  // Boundary codes, back to back, bus disabled
  task automatic s_codes();
    logic [RES_BITS-1:0] tbl [6] = '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'ha5c, 12'h001};
    foreach (tbl[i])
      run_conv(tbl[i], 1'b0);
  endtask
  // Every strobe combination; only both low drives the bus
  task automatic s_read();
    for (int i = 0; i < 4; i++)
    begin
      u_host_side.strobes(i[1], i[0]);
      repeat (3) @(posedge clock_in);
      #1;
      chk("read enable", RES_BITS'(i == 0), RES_BITS'(oe));
      chk("read data", 12'h001, result);
    end
  endtask
  // Both strobes tied low across two conversions
  task automatic s_tied();
    u_host_side.strobes(1'b0, 1'b0);
    repeat (4) @(posedge clock_in);
    run_conv(12'h3c5, 1'b0);
    run_conv(12'hc3a, 1'b0);
    u_host_side.strobes(1'b1, 1'b1);
    repeat (4) @(posedge clock_in);
  endtask
  // Start held low to the end: sleep, then wake on the rising edge
  task automatic s_sleep();
    int n;
    n = 0;
    run_conv(12'h5a5, 1'b1);
    repeat (5) @(posedge clock_in);
    #1;
    chk("still asleep", 12'h001, RES_BITS'(sleep && !busy));
    u_host_side.release_start();
    while (sleep === 1'b1 && n < 80)
    begin
      @(posedge clock_in) #1;
      n++;
    end
    chk("wake time", 12'h001, RES_BITS'(n >= WAKE_CYC && n <= WAKE_CYC + 5));
    run_conv(12'h0f0, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    rst_b_in = 1'b0;
    repeat (3) @(posedge clock_in);
    #1;
    rst_b_in = 1'b1;
    chk("reset state", 12'h000, RES_BITS'({busy, hold, sleep, oe}));
    chk("reset result", RESULT_RST, result);
    s_codes();
    s_read();
    s_tied();
    s_sleep();
    results();
  end
  // Watchdog well past the expected run of a few hundred cycles
  initial
  begin
    #(25 * 5000);
    num_errors++;
    $display("Error watchdog expected end seen hang");
    results();
  end
endmodule
`default_nettype wire
